/* rtl/oscillator_control_regs.sv */
// Oscillator control register bank with clear/set/invert aliases on classic Wishbone.
// How it works
// - Control, tuning, reference and trim registers have clear, set and invert aliases at offsets 4, 8 and c.
// - Alias writes clear, set or toggle valid bits where the written bit is one.
// - PLL output divider bits 29-27 select ratios 1 through 64 and 256.
// - PLL output divider loads from configuration word two bits 18:16 at reset.
// - Fast RC divider bits 26-24 select ratios 1 through 64 and 256.
// - Fast RC divider resets to code one, divide by two.
// - Bit 22 reads one only when the secondary oscillator is stable.
// - Bit 21 reads one when the peripheral divisor may be written; resets one.
// - Bits 31-30 and 23 read zero and ignore writes.
// - Reading the control register clears the clock fail flag.
// - A six-bit tuning field adjusts the fast RC oscillator frequency.
// - Trim register gives fractional trim to the 15-bit reference divider.
// - Control register steers switching and reports source, lock and failure.
// - A monitor flags failure of the active clock.
// - Peripheral divisor codes divide by 1, 2, 4, 8; default code three.
// - Switch enable starts a source change and reads zero when done.
// - Control and tuning writes need the unlock sequence first.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`default_nettype none
module oscillator_control_regs
   import osc_regs_pkg::*;
#(
   parameter int FAIL_TIMEOUT = 16
) (
   input  wire logic        clk_i,          // 20 MHz bus clock.
   input  wire logic        rst_i,          // Synchronous reset, active high.
   input  wire logic        cyc_i,          // Wishbone cycle.
   input  wire logic        stb_i,          // Wishbone strobe.
   input  wire logic        we_i,           // Wishbone write enable.
   input  wire logic [7:0]  adr_i,          // Wishbone byte address.
   input  wire logic [3:0]  sel_i,          // Wishbone byte selects.
   input  wire logic [31:0] dat_i,          // Wishbone write data.
   output logic      [31:0] dat_o,          // Wishbone read data.
   output logic             ack_o,          // Wishbone acknowledge.
   input  wire logic [31:0] config_word_two_i, // Configuration word two.
   input  wire logic [1:0]  config_pb_div_i,   // Peripheral divisor power-on value.
   input  wire logic [2:0]  config_new_src_i,  // Power-on clock source.
   input  wire logic [2:0]  config_pll_mult_i, // Power-on PLL multiplier.
   input  wire logic        secondary_osc_stable_i, // Secondary oscillator stable.
   input  wire logic        pll_locked_i,   // PLL lock status.
   input  wire logic        clk_activity_i, // Toggle from active clock.
   output logic      [2:0]  current_source_o, // Clock source in use.
   output logic      [8:0]  pll_out_ratio_o,  // PLL output divide ratio.
   output logic      [8:0]  fast_rc_ratio_o,  // Fast RC divide ratio.
   output logic      [3:0]  periph_ratio_o,   // Peripheral clock divide ratio.
   output logic      [5:0]  tuning_field_o,   // Fast RC tuning.
   output logic      [14:0] reference_divider_o, // Reference divider.
   output logic      [8:0]  reference_trim_field_o, // Reference trim.
   output logic             secondary_osc_en_o, // Secondary oscillator enable.
   output logic             clock_fail_flag_o   // Clock failure flagged.
);
   initial begin
      if (FAIL_TIMEOUT < 2) $error("FAIL_TIMEOUT too small");
   end

   logic [31:0] ctrl_ff, tun_ff, refc_ff, trim_ff;
   logic [31:0] nxt_ctrl, nxt_tun, nxt_refc, nxt_trim;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  unlock_ff;
   logic [2:0]  cur_src_ff;
   logic        sosc_rdy_ff;
   logic        pb_rdy_ff;
   logic [3:0]  pb_busy_ff;
   logic [7:0]  sw_cnt_ff;
   logic        sw_active_ff;
   logic        fail_pulse;
   logic        por_load_ff;

   wire req      = cyc_i && stb_i && !ack_ff;
   wire wr       = req && we_i;
   wire rd       = req && !we_i;
   wire [1:0] al = adr_i[3:2];
   wire [7:0] base = {adr_i[7:4], 4'h0};
   wire unlocked = (unlock_ff == 2'h2);

   logic [31:0] bmask;
   always_comb begin
      bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   end

   // Alias arithmetic applied to one register in a single cycle.
   function automatic logic [31:0] apply(input logic [31:0] cur, input logic [31:0] d,
                                         input logic [31:0] m, input logic [1:0] kind);
      logic [31:0] r;
      r = cur;
      unique case (kind)
         ALIAS_NONE: r = (cur & ~m) | (d & m);
         ALIAS_CLR:  r = cur & ~(d & m);
         ALIAS_SET:  r = cur | (d & m);
         ALIAS_INV:  r = cur ^ (d & m);
      endcase
      return r;
   endfunction

   // Wishbone answer: one wait state, ack one cycle after the strobe is seen.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end
   assign ack_o = ack_ff;
   assign dat_o = rdata_ff;

   // Unlock sequence: two keys in order arm one control or tuning write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_ff <= 2'h0;
      end else if (wr && base == OFF_UNLOCK) begin
         if (dat_i == UNLOCK_KEY1) begin
            unlock_ff <= 2'h1;
         end else if (dat_i == UNLOCK_KEY2 && unlock_ff == 2'h1) begin
            unlock_ff <= 2'h2;
         end else begin
            unlock_ff <= 2'h0;
         end
      end else if (wr && unlocked && (base == OFF_OSC_CTRL || base == OFF_TUNING)) begin
         unlock_ff <= 2'h0;
      end
   end

   // Next values of the writable register images.
   always_comb begin
      logic [31:0] wc;
      wc       = apply(ctrl_ff, dat_i, bmask & MASK_OSC_CTRL, al);
      nxt_ctrl = ctrl_ff;
      nxt_tun  = tun_ff;
      nxt_refc = refc_ff;
      nxt_trim = trim_ff;
      if (wr && unlocked && base == OFF_OSC_CTRL) begin
         nxt_ctrl = wc;
         if (!pb_rdy_ff) begin
            nxt_ctrl[POS_PB_DIV +: 2] = ctrl_ff[POS_PB_DIV +: 2];
         end
         // Clock fail is hardware set; software may only clear it.
         nxt_ctrl[POS_CLK_FAIL] = ctrl_ff[POS_CLK_FAIL] & wc[POS_CLK_FAIL];
      end
      if (wr && unlocked && base == OFF_TUNING) begin
         nxt_tun = apply(tun_ff, dat_i, bmask & MASK_TUNING, al);
      end
      if (wr && base == OFF_REF_CTRL) begin
         nxt_refc = apply(refc_ff, dat_i, bmask & MASK_REF_CTRL, al);
      end
      if (wr && base == OFF_REF_TRIM) begin
         nxt_trim = apply(trim_ff, dat_i, bmask & MASK_REF_TRIM, al);
      end
      if (rd && base == OFF_OSC_CTRL && al == ALIAS_NONE) begin
         nxt_ctrl[POS_CLK_FAIL] = 1'b0;
      end
      if (sw_active_ff && sw_cnt_ff == 8'(SWITCH_CYCLES - 1)) begin
         nxt_ctrl[POS_SWITCH_EN] = 1'b0;
      end
      if (fail_pulse) begin
         nxt_ctrl[POS_CLK_FAIL] = 1'b1;
      end
      nxt_ctrl = nxt_ctrl & MASK_OSC_CTRL;
   end

   // Power-on values; configuration-word fields are caught the cycle after release.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_load_ff <= 1'b1;
         ctrl_ff     <= 32'h0;
         ctrl_ff[POS_FRC_DIV +: 3] <= RST_FRC_DIV;
         ctrl_ff[POS_PB_DIV +: 2]  <= RST_PB_DIV;
         tun_ff      <= 32'h0;
         refc_ff     <= 32'h0;
         trim_ff     <= 32'h0;
      end else if (por_load_ff) begin
         por_load_ff <= 1'b0;
         ctrl_ff[POS_PLL_ODIV +: 3] <= config_word_two_i[CFG_ODIV_LSB +: 3];
         ctrl_ff[POS_PB_DIV +: 2]   <= config_pb_div_i;
         ctrl_ff[POS_PLL_MULT +: 3] <= config_pll_mult_i;
         ctrl_ff[POS_NEW_SRC +: 3]  <= config_new_src_i;
      end else begin
         ctrl_ff <= nxt_ctrl;
         tun_ff  <= nxt_tun;
         refc_ff <= nxt_refc;
         trim_ff <= nxt_trim;
      end
   end

   // Clock switch sequencing: count out the switch time, then adopt the new source.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_active_ff <= 1'b0;
         sw_cnt_ff    <= 8'h0;
         cur_src_ff   <= 3'h0;
      end else if (por_load_ff) begin
         cur_src_ff   <= config_new_src_i;
      end else if (!sw_active_ff) begin
         sw_cnt_ff    <= 8'h0;
         sw_active_ff <= ctrl_ff[POS_SWITCH_EN];
      end else if (sw_cnt_ff == 8'(SWITCH_CYCLES - 1)) begin
         sw_active_ff <= 1'b0;
         cur_src_ff   <= ctrl_ff[POS_NEW_SRC +: 3];
      end else begin
         sw_cnt_ff    <= sw_cnt_ff + 8'h1;
      end
   end

   // Peripheral divisor ready drops while a new divisor settles.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pb_rdy_ff  <= 1'b1;
         pb_busy_ff <= 4'h0;
      end else if (ctrl_ff[POS_PB_DIV +: 2] != nxt_ctrl[POS_PB_DIV +: 2] && !por_load_ff) begin
         pb_rdy_ff  <= 1'b0;
         pb_busy_ff <= 4'(PB_BUSY_CYCLES);
      end else if (pb_busy_ff != 4'h0) begin
         pb_busy_ff <= pb_busy_ff - 4'h1;
         pb_rdy_ff  <= (pb_busy_ff == 4'h1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sosc_rdy_ff <= 1'b0;
      end else begin
         sosc_rdy_ff <= secondary_osc_stable_i && ctrl_ff[POS_SOSC_EN];
      end
   end

   // Composed control register view with status fields.
   logic [31:0] ctrl_view;
   always_comb begin
      ctrl_view = ctrl_ff & MASK_OSC_CTRL;
      ctrl_view[POS_SOSC_RDY] = sosc_rdy_ff;
      ctrl_view[POS_PB_RDY]   = pb_rdy_ff;
      ctrl_view[POS_CUR_SRC +: 3] = cur_src_ff;
      ctrl_view[POS_PLL_LOCK] = pll_locked_i;
   end

   // Read data; alias reads return zero and carry no meaning.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0;
      end else if (rd) begin
         rdata_ff <= 32'h0;
         if (al == ALIAS_NONE) begin
            unique case (base)
               OFF_OSC_CTRL: rdata_ff <= ctrl_view;
               OFF_TUNING:   rdata_ff <= tun_ff;
               OFF_REF_CTRL: rdata_ff <= refc_ff;
               OFF_REF_TRIM: rdata_ff <= trim_ff;
               default:      rdata_ff <= 32'h0;
            endcase
         end
      end
   end

   clock_fail_monitor #(
      .TIMEOUT (FAIL_TIMEOUT)
   ) u_fail (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .enable_i (!por_load_ff),
      .act_i    (clk_activity_i),
      .fail_o   (fail_pulse)
   );

   pow2_divider u_pll_div (
      .code_i  (ctrl_ff[POS_PLL_ODIV +: 3]),
      .ratio_o (pll_out_ratio_o)
   );

   pow2_divider u_frc_div (
      .code_i  (ctrl_ff[POS_FRC_DIV +: 3]),
      .ratio_o (fast_rc_ratio_o)
   );

   assign periph_ratio_o         = 4'h1 << ctrl_ff[POS_PB_DIV +: 2];
   assign current_source_o       = cur_src_ff;
   assign tuning_field_o         = tun_ff[5:0];
   assign reference_divider_o    = refc_ff[30:16];
   assign reference_trim_field_o = trim_ff[31:23];
   assign secondary_osc_en_o     = ctrl_ff[POS_SOSC_EN];
   assign clock_fail_flag_o      = ctrl_ff[POS_CLK_FAIL];
endmodule
`default_nettype wire

/* rtl/osc_regs_pkg.sv */
// Package with register map, field layout and timing constants of the oscillator register bank.
`default_nettype none
package osc_regs_pkg;
   // Register byte offsets (base registers); aliases sit at +4, +8 and +c.
   localparam logic [7:0] OFF_OSC_CTRL  = 8'h00;
   localparam logic [7:0] OFF_TUNING    = 8'h10;
   localparam logic [7:0] OFF_REF_CTRL  = 8'h20;
   localparam logic [7:0] OFF_REF_TRIM  = 8'h30;
   localparam logic [7:0] OFF_UNLOCK    = 8'h40;
   localparam logic [1:0] ALIAS_NONE    = 2'h0;
   localparam logic [1:0] ALIAS_CLR     = 2'h1;
   localparam logic [1:0] ALIAS_SET     = 2'h2;
   localparam logic [1:0] ALIAS_INV     = 2'h3;
   // Unlock keys, written in order to the unlock register.
   localparam logic [31:0] UNLOCK_KEY1  = 32'haa996655;
   localparam logic [31:0] UNLOCK_KEY2  = 32'h556699aa;
   // Oscillator control field positions.
   localparam int POS_PLL_ODIV   = 27;
   localparam int POS_FRC_DIV    = 24;
   localparam int POS_SOSC_RDY   = 22;
   localparam int POS_PB_RDY     = 21;
   localparam int POS_PB_DIV     = 19;
   localparam int POS_PLL_MULT   = 16;
   localparam int POS_CUR_SRC    = 12;
   localparam int POS_NEW_SRC    = 8;
   localparam int POS_CLK_LOCK   = 7;
   localparam int POS_PLL_LOCK   = 5;
   localparam int POS_SLEEP_EN   = 4;
   localparam int POS_CLK_FAIL   = 3;
   localparam int POS_SOSC_EN    = 1;
   localparam int POS_SWITCH_EN  = 0;
   // Writable masks of each register.
   localparam logic [31:0] MASK_OSC_CTRL = 32'h3f1f079f;
   localparam logic [31:0] MASK_TUNING   = 32'h0000003f;
   localparam logic [31:0] MASK_REF_CTRL = 32'h7fffb30f;
   localparam logic [31:0] MASK_REF_TRIM = 32'hff800000;
   // Reset values.
   localparam logic [2:0] RST_FRC_DIV    = 3'h1;
   localparam logic [1:0] RST_PB_DIV     = 2'h3;
   localparam int         CFG_ODIV_LSB   = 16;
   // Clock timing: 20 MHz bus clock.
   localparam int CLK_HZ          = 20_000_000;
   localparam int SWITCH_TIME_NS  = 1000;
   localparam int SWITCH_CYCLES   = (SWITCH_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int PB_BUSY_CYCLES  = 8;
endpackage
`default_nettype wire

/* rtl/pow2_divider.sv */
// Power-of-two divide ratio decoder: codes 0..7 give 1,2,4,8,16,32,64,256.
`default_nettype none
module pow2_divider
   import osc_regs_pkg::*;
(
   input  wire logic [2:0] code_i,   // Divider code.
   output logic      [8:0] ratio_o   // Decoded ratio.
);
   always_comb begin
      if (code_i == 3'h7) begin
         ratio_o = 9'h100;
      end else begin
         ratio_o = 9'h001 << code_i;
      end
   end
endmodule
`default_nettype wire

/* rtl/clock_fail_monitor.sv */
// Watchdog that flags a stall of the monitored clock's activity toggle.
`default_nettype none
module clock_fail_monitor #(
   parameter int TIMEOUT = 16
) (
   input  wire logic clk_i,       // Bus clock.
   input  wire logic rst_i,       // Synchronous reset.
   input  wire logic enable_i,    // Monitoring allowed.
   input  wire logic act_i,       // Toggle from the active clock domain.
   output logic      fail_o       // One-cycle pulse on failure.
);
   initial begin
      if (TIMEOUT < 2) $error("TIMEOUT too small");
   end
   logic [1:0]  sync_ff;
   logic        last_ff;
   logic [15:0] cnt_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_ff <= 2'h0;
         last_ff <= 1'b0;
      end else begin
         sync_ff <= {sync_ff[0], act_i};
         last_ff <= sync_ff[1];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i || (sync_ff[1] != last_ff)) begin
         cnt_ff <= 16'h0;
      end else if (cnt_ff != 16'(TIMEOUT)) begin
         cnt_ff <= cnt_ff + 16'h1;
      end
   end
   assign fail_o = enable_i && (cnt_ff == 16'(TIMEOUT - 1)) && (sync_ff[1] == last_ff);
endmodule
`default_nettype wire

/* sim/osc_regs_properties.sv */
// Checker of the bus handshake and decoded fields of the oscillator register bank.
`default_nettype none
module osc_regs_properties
   import osc_regs_pkg::*;
#(
   parameter int FAIL_TIMEOUT = 16
) (
   input wire logic        clk_i,             // Bus clock.
   input wire logic        rst_i,             // Synchronous reset.
   input wire logic        cyc_i,             // Bus cycle.
   input wire logic        stb_i,             // Bus strobe.
   input wire logic        we_i,              // Write enable.
   input wire logic [7:0]  adr_i,             // Byte address.
   input wire logic [31:0] dat_o,             // Read data.
   input wire logic        ack_o,             // Acknowledge.
   input wire logic        clk_activity_i,    // Active clock toggle.
   input wire logic [8:0]  pll_out_ratio_o,   // PLL output ratio.
   input wire logic [8:0]  fast_rc_ratio_o,   // Fast RC ratio.
   input wire logic [3:0]  periph_ratio_o,    // Peripheral ratio.
   input wire logic        clock_fail_flag_o  // Failure flag.
);
   logic rd_ctrl;
   logic rd_take;

   function automatic logic [8:0] ratio_of(input logic [2:0] c);
      return (c == 3'h7) ? 9'h100 : 9'h001 << c;
   endfunction

   assign rd_ctrl = ack_o && !we_i && adr_i == OFF_OSC_CTRL;
   // A control read is taken on the edge where the strobe is seen and ack is still low.
   assign rd_take = cyc_i && stb_i && !ack_o && !we_i && adr_i == OFF_OSC_CTRL;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   unimpl_zero_a: assert property (rd_ctrl |-> dat_o[31:30] == 2'h0 && !dat_o[23])
      else $error("unimplemented bits set");
   pll_ratio_a: assert property (rd_ctrl |-> pll_out_ratio_o == ratio_of(dat_o[29:27]))
      else $error("pll ratio wrong");
   frc_ratio_a: assert property (rd_ctrl |-> fast_rc_ratio_o == ratio_of(dat_o[26:24]))
      else $error("fast rc ratio wrong");
   pb_ratio_a: assert property (rd_ctrl |-> periph_ratio_o == 4'h1 << dat_o[20:19])
      else $error("peripheral ratio wrong");
   sosc_ready_a: assert property (rd_ctrl && dat_o[22] |-> dat_o[1])
      else $error("ready without enable");
   fail_clear_a: assert property (rd_take && clock_fail_flag_o |=> !clock_fail_flag_o)
      else $error("fail flag not cleared by read");
   fail_cause_a: assert property ($rose(clock_fail_flag_o) |->
      $past(clk_activity_i) == $past(clk_activity_i, 2))
      else $error("fail flag while clock active");
endmodule

bind oscillator_control_regs osc_regs_properties #(.FAIL_TIMEOUT(FAIL_TIMEOUT))
   i_osc_regs_properties (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
   .clk_activity_i, .pll_out_ratio_o, .fast_rc_ratio_o, .periph_ratio_o, .clock_fail_flag_o);
`default_nettype wire

/* sim/oscillator_control_regs_tb_top.sv */
// Self-checking bench of the oscillator register bank over classic Wishbone.
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) begin \
         fails++; \
         $display("BAD %s expected %h seen %h", nm, e, g); \
      end \
   end
module oscillator_control_regs_tb_top
   import osc_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q, z;
   logic        ack_o, secondary_osc_stable_i = 1'b1, pll_locked_i = 1'b1;
   logic        clk_activity_i = 1'b0, run = 1'b1;
   logic [2:0]  current_source_o;
   logic [8:0]  pll_out_ratio_o, fast_rc_ratio_o, reference_trim_field_o;
   logic [3:0]  periph_ratio_o;
   logic [5:0]  tuning_field_o;
   logic [14:0] reference_divider_o;
   logic        secondary_osc_en_o, clock_fail_flag_o;
   int          fails = 0, samples_checked = 0;

   oscillator_control_regs #(.FAIL_TIMEOUT(4)) i_oscillator_control_regs (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .config_word_two_i(32'h00050000), .config_pb_div_i(2'h3),
      .config_new_src_i(3'h7), .config_pll_mult_i(3'h2),
      .secondary_osc_stable_i, .pll_locked_i, .clk_activity_i, .current_source_o,
      .pll_out_ratio_o, .fast_rc_ratio_o, .periph_ratio_o, .tuning_field_o,
      .reference_divider_o, .reference_trim_field_o, .secondary_osc_en_o, .clock_fail_flag_o);

   always #25 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      if (run) begin
         clk_activity_i <= ~clk_activity_i;
      end
   end

   function automatic logic [8:0] ratio_of(input logic [2:0] c);
      return (c == 3'h7) ? 9'h100 : 9'h001 << c;
   endfunction

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      // The watchdog ends a wait that never sees ack.
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, z);
   endtask

   // Unlocks, then performs the single write that the unlock arms.
   task automatic uwr(input logic [7:0] a, input logic [31:0] d);
      wr(OFF_UNLOCK, UNLOCK_KEY1);
      wr(OFF_UNLOCK, UNLOCK_KEY2);
      wr(a, d);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(50 * 6000);
      fails++;
      results();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFF_OSC_CTRL);
      `CHK("pll_div", 3'h5, q[29:27])
      `CHK("frc_div", 3'h1, q[26:24])
      `CHK("sosc_rdy", 1'b0, q[22])
      `CHK("pb_rdy", 1'b1, q[21])
      `CHK("cur_src", 3'h7, q[14:12])
      `CHK("new_src", 3'h7, q[10:8])
      `CHK("pll_mult", 3'h2, q[18:16])
      `CHK("pb_div", 2'h3, q[20:19])
      `CHK("sosc_en_off", 1'b0, secondary_osc_en_o)
      `CHK("frc_ratio", 9'h002, fast_rc_ratio_o)
      $display("test reset done");
      wr(OFF_OSC_CTRL, 32'h0);
      wr(OFF_TUNING, 32'hffffffff);
      rd(OFF_OSC_CTRL);
      `CHK("locked_ctrl", 3'h1, q[26:24])
      rd(OFF_TUNING);
      `CHK("locked_tun", 32'h0, q)
      uwr(OFF_OSC_CTRL + 8'h08, 32'hc6800000);
      rd(OFF_OSC_CTRL);
      `CHK("set_alias", 3'h7, q[26:24])
      `CHK("unimpl", 3'h0, {q[31:30], q[23]})
      rd(OFF_OSC_CTRL + 8'h08);
      uwr(OFF_OSC_CTRL + 8'h04, 32'h02000000);
      uwr(OFF_OSC_CTRL + 8'h0c, 32'hf8800000);
      rd(OFF_OSC_CTRL);
      `CHK("clr_alias", 3'h5, q[26:24])
      `CHK("inv_alias", 3'h2, q[29:27])
      `CHK("unimpl_inv", 3'h0, {q[31:30], q[23]})
      for (int c = 0; c < 8; c++) begin
         uwr(OFF_OSC_CTRL, (q & 32'hc0fffffe) | {2'h0, c[2:0], c[2:0], 24'h0});
         `CHK("pll_ratio", ratio_of(c[2:0]), pll_out_ratio_o)
         `CHK("frc_ratio", ratio_of(c[2:0]), fast_rc_ratio_o)
      end
      $display("test dividers done");
      for (int c = 0; c < 4; c++) begin
         uwr(OFF_OSC_CTRL, (q & 32'hffe7fffe) | {11'h0, c[1:0], 19'h0});
         `CHK("pb_ratio", 4'h1 << c, periph_ratio_o)
         rd(OFF_OSC_CTRL);
         `CHK("pb_busy", 1'b0, q[21])
         repeat (PB_BUSY_CYCLES + 2) @(posedge clk_i);
         rd(OFF_OSC_CTRL);
         `CHK("pb_ready", 1'b1, q[21])
      end
      $display("test peripheral divisor done");
      uwr(OFF_TUNING, 32'hffffffff);
      rd(OFF_TUNING);
      `CHK("tuning", 32'h0000003f, q)
      `CHK("tuning_out", 6'h3f, tuning_field_o)
      wr(OFF_REF_CTRL, 32'hffffffff);
      wr(OFF_REF_TRIM, 32'hffffffff);
      rd(OFF_REF_CTRL);
      `CHK("ref_div", 16'h7fff, q[31:16])
      `CHK("ref_div_out", 15'h7fff, reference_divider_o)
      rd(OFF_REF_TRIM);
      `CHK("ref_trim", 32'hff800000, q)
      `CHK("ref_trim_out", 9'h1ff, reference_trim_field_o)
      wr(OFF_REF_CTRL + 8'h04, 32'h7fff0000);
      wr(OFF_REF_TRIM + 8'h0c, 32'hff800000);
      `CHK("ref_clr", 15'h0000, reference_divider_o)
      `CHK("trim_inv", 9'h000, reference_trim_field_o)
      $display("test tuning and reference done");
      rd(OFF_OSC_CTRL);
      uwr(OFF_OSC_CTRL, (q & 32'hfffff8fe) | 32'h00000201);
      rd(OFF_OSC_CTRL);
      `CHK("switch_busy", 1'b1, q[0])
      repeat (SWITCH_CYCLES + 4) @(posedge clk_i);
      rd(OFF_OSC_CTRL);
      `CHK("switch_done", 1'b0, q[0])
      `CHK("cur_src_rd", 3'h2, q[14:12])
      `CHK("cur_src_out", 3'h2, current_source_o)
      uwr(OFF_OSC_CTRL + 8'h08, 32'h00000002);
      rd(OFF_OSC_CTRL);
      `CHK("sosc_rdy_on", 2'h3, {q[22], q[5]})
      `CHK("sosc_en_on", 1'b1, secondary_osc_en_o)
      secondary_osc_stable_i <= 1'b0;
      pll_locked_i <= 1'b0;
      rd(OFF_OSC_CTRL);
      `CHK("sosc_rdy_off", 2'h0, {q[22], q[5]})
      $display("test switch and status done");
      run <= 1'b0;
      repeat (10) @(posedge clk_i);
      `CHK("fail_out", 1'b1, clock_fail_flag_o)
      rd(OFF_OSC_CTRL);
      `CHK("fail_bit", 1'b1, q[3])
      rd(OFF_OSC_CTRL);
      `CHK("fail_clr", 2'h0, {q[3], clock_fail_flag_o})
      run <= 1'b1;
      $display("test clock fail done");
      results();
   end
endmodule
`undef CHK
`default_nettype wire
